// ---- logic/cbf_consts.svh ----
// register offsets, field positions, reset values and opcodes
`ifndef CBF_CONSTS_SVH
`define CBF_CONSTS_SVH
`define CBF_REG_CTRL 8'h00
`define CBF_REG_STATUS 8'h04
`define CBF_REG_CTX_BASE 8'h08
`define CBF_REG_CTX_LINES 8'h0C
`define CBF_REG_RING_BASE 8'h10
`define CBF_REG_RING_SIZE 8'h14
`define CBF_REG_RING_TAIL 8'h18
`define CBF_REG_RING_HEAD 8'h1C
`define CBF_REG_FUNC_ID 8'h20
`define CBF_REG_CMD_COUNT 8'h24
`define CBF_CTRL_GO_BIT 0
`define CBF_ENABLE_BIT 0
`define CBF_RING_MAX 22'h200000
`define CBF_ENG_OFS 32'h00000040
`define CBF_RCTX_WORDS 4'h3
`define CBF_LINE_LAST 4'hF
`define CBF_CLIENT_MI 3'h0
`define CBF_MI_MULTI_OP 5'h10
`define CBF_MI_OP_TERM 5'h0A
`define CBF_MI_OP_LAUNCH 5'h11
`define CBF_SRC_RING 2'h0
`define CBF_SRC_BATCH 2'h1
`define CBF_SRC_HOOK 2'h2
`define CBF_RST_FUNC_ID 8'h00
`endif

// ---- logic/cbf_pkg.sv ----
// state types of the command fetch front end
package cbf_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RCTX, ST_ENG, ST_HOOK, ST_BATCH, ST_RING
  } cbf_state_e;
  typedef struct packed {
    cbf_state_e st;
    logic waitreq;
    logic [31:0] rdata;
    logic [31:0] ctx_base;
    logic [15:0] ctx_lines;
    logic [31:0] ring_base;
    logic [21:0] ring_size;
    logic [20:0] ring_tail;
    logic [20:0] head;
    logic [7:0] func_id;
    logic mem_req;
    logic [31:0] mem_addr;
    logic mem_global;
    logic [3:0] cnt;
    logic [15:0] line;
    logic [31:0] hook_ptr;
    logic [15:0] hook_size;
    logic [15:0] hook_off;
    logic [31:0] post_ptr;
    logic hook_done;
    logic [31:0] ptr;
    logic [31:0] buf_end;
    logic [15:0] rem;
    logic launch_arm;
    logic launch_pend;
    logic [31:0] batch_addr;
    logic cmd_valid;
    logic cmd_first;
    logic [2:0] cmd_client;
    logic [1:0] cmd_src;
    logic [31:0] cmd_data;
    logic rst_valid;
    logic [19:0] rst_index;
    logic [31:0] rst_data;
    logic [31:0] cmd_count;
  } cbf_regs_s;
endpackage

// ---- logic/cbf_top.sv ----
// command fetch front end with context restore hooks
//
// How it works
// - a ring is at most 2MB long; ring size logic covers that.
// - a buffer end address names its last valid QWord.
// - batch fetch addresses span the full 4GB space.
// - workaround sequences run during restore, before any ring command.
// - enabled hook pauses restore at a cacheline, runs its buffer, resumes.
// - hook address from hook pointer, size from hook size, pause from hook offset.
// - hook values come from ring context; offset lies in ring part too.
// - hook and post batch fetch through the global translation space.
// - each context carries its own hook settings in its image.
// - enabled post batch starts after all restore commands completed.
// - post batch ends on a batch terminate command.
// - post batch skipped when its restored pointer disables it.
// - first DWord is the header; its client field routes the command.
// - commands are whole DWords; length implied or from header field.
// - memory interface header type 000 in 31:29, opcode in 28:24.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`include "cbf_consts.svh"

module cbf_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic mem_read,
  output logic [31:0] mem_address,
  output logic mem_global,
  output logic [7:0] mem_function,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic cmd_valid,
  output logic cmd_first,
  output logic [2:0] cmd_client,
  output logic [1:0] cmd_source,
  output logic [31:0] cmd_data,
  output logic restore_valid,
  output logic [19:0] restore_index,
  output logic [31:0] restore_data
);

  cbf_pkg::cbf_regs_s r;
  cbf_pkg::cbf_regs_s next_r;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    be_merge = (old & ~m) | (wd & m);
  endfunction

  function automatic logic is_mi_op(input logic [31:0] h,
                                    input logic [4:0] op);
    is_mi_op = (h[31:29] == `CBF_CLIENT_MI) && (h[28:24] == op);
  endfunction

  // DWords that follow the header
  function automatic logic [15:0] cmd_len(input logic [31:0] h);
    cmd_len = 16'h0000;
    case (h[31:29])
      3'h0: begin
        if (h[28:24] >= `CBF_MI_MULTI_OP) begin
          cmd_len = {10'h000, h[5:0]} + 16'h0001;
        end
      end
      3'h1, 3'h2: cmd_len = h[15:0] + 16'h0001;
      3'h3: cmd_len = {8'h00, h[7:0]} + 16'h0001;
      default: cmd_len = 16'h0000;
    endcase
  endfunction

  logic hook_en;
  logic post_en;
  logic av_req;
  logic av_wr;
  logic [31:0] cur;
  logic [31:0] cap;
  logic [21:0] head_inc;

  assign hook_en = r.hook_ptr[`CBF_ENABLE_BIT] && (r.hook_size != 16'h0000);
  assign post_en = r.post_ptr[`CBF_ENABLE_BIT];
  assign av_req = (avs_read || avs_write) && r.waitreq;
  assign av_wr = avs_write && !r.waitreq;
  assign cur = r.rdata;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    cap = 32'h00000000;
    head_inc = 22'h000000;
    next_r = r;
    next_r.cmd_valid = 1'b0;
    next_r.rst_valid = 1'b0;
    // one wait cycle per access, then the answer
    next_r.waitreq = !av_req;
    if (av_req) begin
      case (avs_address)
        `CBF_REG_STATUS: next_r.rdata = {26'h0, r.hook_done,
                                         r.st != cbf_pkg::ST_IDLE,
                                         1'b0, r.st};
        `CBF_REG_CTX_BASE: next_r.rdata = r.ctx_base;
        `CBF_REG_CTX_LINES: next_r.rdata = {16'h0000, r.ctx_lines};
        `CBF_REG_RING_BASE: next_r.rdata = r.ring_base;
        `CBF_REG_RING_SIZE: next_r.rdata = {10'h000, r.ring_size};
        `CBF_REG_RING_TAIL: next_r.rdata = {11'h000, r.ring_tail};
        `CBF_REG_RING_HEAD: next_r.rdata = {11'h000, r.head};
        `CBF_REG_FUNC_ID: next_r.rdata = {24'h000000, r.func_id};
        `CBF_REG_CMD_COUNT: next_r.rdata = r.cmd_count;
        default: next_r.rdata = 32'h00000000;
      endcase
    end
    if (av_wr) begin
      case (avs_address)
        `CBF_REG_CTRL: begin
          if (avs_byteenable[0] && avs_writedata[`CBF_CTRL_GO_BIT] &&
              !r.mem_req && r.rem == 16'h0000 &&
              (r.st == cbf_pkg::ST_IDLE || (r.st == cbf_pkg::ST_RING &&
               r.head == r.ring_tail))) begin
            // new context: its own hook values are reloaded
            next_r.st = cbf_pkg::ST_RCTX;
            next_r.cnt = 4'h0;
            next_r.line = 16'h0000;
            next_r.hook_done = 1'b0;
          end
        end
        `CBF_REG_CTX_BASE: begin
          next_r.ctx_base = be_merge(r.ctx_base, avs_writedata,
                                     avs_byteenable);
          next_r.ctx_base[5:0] = 6'h00;
        end
        `CBF_REG_CTX_LINES: next_r.ctx_lines = 16'(be_merge(
          {16'h0000, r.ctx_lines}, avs_writedata, avs_byteenable));
        `CBF_REG_RING_BASE: begin
          next_r.ring_base = be_merge(r.ring_base, avs_writedata,
                                      avs_byteenable);
          next_r.ring_base[11:0] = 12'h000;
          next_r.head = 21'h000000;
        end
        `CBF_REG_RING_SIZE: begin
          next_r.ring_size = 22'(be_merge({10'h000, r.ring_size},
                                          avs_writedata, avs_byteenable));
          if (next_r.ring_size > `CBF_RING_MAX) begin
            next_r.ring_size = `CBF_RING_MAX;
          end
          next_r.ring_size[1:0] = 2'h0;
        end
        `CBF_REG_RING_TAIL: begin
          next_r.ring_tail = 21'(be_merge({11'h000, r.ring_tail},
                                          avs_writedata, avs_byteenable));
          next_r.ring_tail[2:0] = 3'h0;
        end
        `CBF_REG_FUNC_ID: next_r.func_id = 8'(be_merge({24'h0, r.func_id},
                                          avs_writedata, avs_byteenable));
        default: begin
        end
      endcase
    end

    if (r.mem_req && mem_ack) begin
      next_r.mem_req = 1'b0;
      case (r.st)
        cbf_pkg::ST_RCTX: begin
          // hook values sit in the ring part, ahead of the engine part
          case (r.cnt[1:0])
            2'h0: next_r.hook_ptr = mem_rdata;
            2'h1: next_r.hook_size = mem_rdata[15:0];
            2'h2: next_r.hook_off = mem_rdata[15:0];
            default: next_r.post_ptr = mem_rdata;
          endcase
          next_r.cnt = r.cnt + 4'h1;
          if (r.cnt == `CBF_RCTX_WORDS) begin
            next_r.st = cbf_pkg::ST_ENG;
            next_r.cnt = 4'h0;
          end
        end
        cbf_pkg::ST_ENG: begin
          next_r.rst_valid = 1'b1;
          next_r.rst_data = mem_rdata;
          next_r.rst_index = {r.line, r.cnt};
          next_r.cnt = r.cnt + 4'h1;
          if (r.cnt == `CBF_LINE_LAST) begin
            next_r.line = r.line + 16'h0001;
          end
        end
        default: begin
          next_r.cmd_valid = 1'b1;
          next_r.cmd_data = mem_rdata;
          next_r.cmd_first = (r.rem == 16'h0000);
          next_r.cmd_count = r.cmd_count + 32'h00000001;
          next_r.cmd_src = (r.st == cbf_pkg::ST_RING) ? `CBF_SRC_RING :
                           (r.st == cbf_pkg::ST_HOOK) ? `CBF_SRC_HOOK :
                           `CBF_SRC_BATCH;
          next_r.ptr = r.ptr + 32'h00000004;
          if (r.st == cbf_pkg::ST_RING) begin
            head_inc = {1'b0, r.head} + 22'h000004;
            next_r.head = (head_inc >= r.ring_size) ? 21'h000000 :
                          head_inc[20:0];
          end
          if (r.rem == 16'h0000) begin
            next_r.rem = cmd_len(mem_rdata);
            next_r.cmd_client = mem_rdata[31:29];
            // nested batches are not followed
            if (is_mi_op(mem_rdata, `CBF_MI_OP_LAUNCH) &&
                r.st == cbf_pkg::ST_RING) begin
              next_r.launch_arm = 1'b1;
              next_r.launch_pend = 1'b1;
            end
            if (is_mi_op(mem_rdata, `CBF_MI_OP_TERM)) begin
              if (r.st == cbf_pkg::ST_BATCH) begin
                next_r.st = cbf_pkg::ST_RING;
              end else if (r.st == cbf_pkg::ST_HOOK) begin
                next_r.st = cbf_pkg::ST_ENG;
                next_r.hook_done = 1'b1;
              end
            end
          end else begin
            next_r.rem = r.rem - 16'h0001;
            cap = r.batch_addr;
            if (r.launch_arm) begin
              cap = {mem_rdata[31:3], 3'h0};
              next_r.batch_addr = cap;
              next_r.launch_arm = 1'b0;
            end
            if (r.rem == 16'h0001 && r.launch_pend) begin
              next_r.launch_pend = 1'b0;
              next_r.st = cbf_pkg::ST_BATCH;
              next_r.ptr = cap;
            end
          end
          // last DWord of the last valid QWord closes the hook
          if (r.st == cbf_pkg::ST_HOOK &&
              r.ptr == r.buf_end + 32'h00000004) begin
            next_r.st = cbf_pkg::ST_ENG;
            next_r.hook_done = 1'b1;
            next_r.rem = 16'h0000;
          end
        end
      endcase
    end else if (!r.mem_req) begin
      next_r.mem_global = 1'b0;
      case (r.st)
        cbf_pkg::ST_RCTX: begin
          next_r.mem_req = 1'b1;
          next_r.mem_addr = r.ctx_base + {26'h0, r.cnt, 2'h0};
        end
        cbf_pkg::ST_ENG: begin
          if (r.cnt == 4'h0 && hook_en && !r.hook_done &&
              r.line == r.hook_off) begin
            next_r.st = cbf_pkg::ST_HOOK;
            next_r.ptr = {r.hook_ptr[31:6], 6'h00};
            next_r.buf_end = {r.hook_ptr[31:6], 6'h00} +
                             {10'h000, r.hook_size, 6'h00} - 32'h00000008;
          end else if (r.cnt == 4'h0 && r.line == r.ctx_lines) begin
            if (post_en) begin
              next_r.st = cbf_pkg::ST_BATCH;
              next_r.ptr = {r.post_ptr[31:3], 3'h0};
            end else begin
              next_r.st = cbf_pkg::ST_RING;
            end
          end else begin
            next_r.mem_req = 1'b1;
            next_r.mem_addr = r.ctx_base + `CBF_ENG_OFS +
                              {10'h000, r.line, 6'h00} + {26'h0, r.cnt, 2'h0};
          end
        end
        cbf_pkg::ST_HOOK, cbf_pkg::ST_BATCH: begin
          next_r.mem_req = 1'b1;
          next_r.mem_addr = r.ptr;
          next_r.mem_global = 1'b1;
        end
        cbf_pkg::ST_RING: begin
          // ring commands only once restore is over
          if (r.head != r.ring_tail) begin
            next_r.mem_req = 1'b1;
            next_r.mem_addr = r.ring_base + {11'h000, r.head};
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= cbf_pkg::ST_IDLE;
      r.waitreq <= 1'b1;
      r.func_id <= `CBF_RST_FUNC_ID;
    end else begin
      r <= next_r;
    end
  end

  assign avs_readdata = cur;
  assign avs_waitrequest = r.waitreq;
  assign mem_read = r.mem_req;
  assign mem_address = r.mem_addr;
  assign mem_global = r.mem_global;
  assign mem_function = r.func_id;
  assign cmd_valid = r.cmd_valid;
  assign cmd_first = r.cmd_first;
  assign cmd_client = r.cmd_client;
  assign cmd_source = r.cmd_src;
  assign cmd_data = r.cmd_data;
  assign restore_valid = r.rst_valid;
  assign restore_index = r.rst_index;
  assign restore_data = r.rst_data;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_ring_after_restore;
    r.mem_req && r.st == cbf_pkg::ST_RING |-> r.line == r.ctx_lines;
  endproperty
  a_ring_after_restore: assert property (p_ring_after_restore)
    else $error("ring fetch before engine restore finished");

  property p_hook_pause;
    !r.mem_req && r.st == cbf_pkg::ST_ENG && r.cnt == 4'h0 && hook_en &&
    !r.hook_done && r.line == r.hook_off |=> r.st == cbf_pkg::ST_HOOK;
  endproperty
  a_hook_pause: assert property (p_hook_pause)
    else $error("restore did not pause at hook offset");

  property p_hook_addr;
    $rose(r.st == cbf_pkg::ST_HOOK) |->
      r.ptr == {r.hook_ptr[31:6], 6'h00};
  endproperty
  a_hook_addr: assert property (p_hook_addr)
    else $error("hook buffer start not from hook pointer");

  property p_resume;
    r.st == cbf_pkg::ST_HOOK ##1 r.st == cbf_pkg::ST_ENG |->
      r.line == $past(r.line) && r.cnt == 4'h0 && r.hook_done;
  endproperty
  a_resume: assert property (p_resume)
    else $error("restore did not resume at the pause point");

  property p_global;
    r.mem_req && (r.st == cbf_pkg::ST_HOOK || r.st == cbf_pkg::ST_BATCH)
      |-> r.mem_global;
  endproperty
  a_global: assert property (p_global)
    else $error("workaround fetch outside global space");

  property p_post_start;
    !r.mem_req && r.st == cbf_pkg::ST_ENG && r.cnt == 4'h0 &&
    r.line == r.ctx_lines && !(hook_en && !r.hook_done &&
    r.line == r.hook_off) |=>
      r.st == (post_en ? cbf_pkg::ST_BATCH : cbf_pkg::ST_RING);
  endproperty
  a_post_start: assert property (p_post_start)
    else $error("post restore batch start or skip wrong");

  property p_term;
    r.mem_req && mem_ack && r.st == cbf_pkg::ST_BATCH &&
    r.rem == 16'h0000 && is_mi_op(mem_rdata, `CBF_MI_OP_TERM)
      |=> r.st == cbf_pkg::ST_RING ##1 r.cmd_valid == 1'b0;
  endproperty
  a_term: assert property (p_term)
    else $error("batch terminate did not end the batch");

  property p_client;
    r.mem_req && mem_ack && r.rem == 16'h0000 &&
    r.st inside {cbf_pkg::ST_RING, cbf_pkg::ST_BATCH, cbf_pkg::ST_HOOK}
      |=> cmd_valid && cmd_first && cmd_client == $past(mem_rdata[31:29]);
  endproperty
  a_client: assert property (p_client)
    else $error("header client not routed");

  property p_head_bound;
    r.ring_size != 22'h000000 |-> {1'b0, r.head} < r.ring_size;
  endproperty
  a_head_bound: assert property (p_head_bound)
    else $error("ring head beyond ring limit");

  property p_bus_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("register access not answered next cycle");

endmodule

// ---- testbench/cbf_mem_model.sv ----
// memory model answering command and context fetches
module cbf_mem_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mem_read,
  input wire logic [31:0] mem_address,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // one flat space for commands and the data they reference
  logic [31:0] mem [logic [31:0]];
  logic [1:0] dly;
  // ----------------------------------------
  // contents
  // ----------------------------------------
  function automatic logic [31:0] rd(input logic [31:0] a);
    // reads always see the latest write: coherent
    return mem.exists(a) ? mem[a] : (a ^ 32'hC3C3_0000);
  endfunction
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0000_0000;
    dly = 2'h0;
  end
  // ----------------------------------------
  // one read at a time, random latency
  // ----------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      mem_ack <= 1'b0;
      dly <= 2'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_read && dly == 2'h0) begin
      mem_ack <= 1'b1;
      mem_rdata <= rd(mem_address);
      dly <= 2'($urandom % 4);
    end else begin
      // data line is junk outside an answer
      mem_rdata <= ~mem_rdata;
      if (mem_read) begin
        dly <= dly - 2'h1;
      end
    end
  end
endmodule

// ---- testbench/cbf_top_tb.sv ----
// bench for the command fetch front end
`include "cbf_consts.svh"
module cbf_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, mem_address, mem_rdata, cmd_data, restore_data;
  logic avs_waitrequest, mem_read, mem_global, mem_ack, cmd_valid, cmd_first;
  logic restore_valid;
  logic [7:0] mem_function;
  logic [2:0] cmd_client;
  logic [1:0] cmd_source;
  logic [19:0] restore_index, rcnt;
  logic [31:0] q, cbase, r;
  logic [57:0] expq[$];
  logic [57:0] e;
  int num_errors = 0;
  int checks_done = 0;
  localparam logic [31:0] NOP = 32'h0000_0000;
  localparam logic [31:0] TERM = {3'h0, `CBF_MI_OP_TERM, 24'h000000};
  localparam logic [31:0] LAUNCH = {3'h0, `CBF_MI_OP_LAUNCH, 24'h000000};
  always #2.5 clk = ~clk;
  cbf_top dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_read(mem_read), .mem_address(mem_address),
    .mem_global(mem_global), .mem_function(mem_function),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .cmd_valid(cmd_valid),
    .cmd_first(cmd_first), .cmd_client(cmd_client),
    .cmd_source(cmd_source), .cmd_data(cmd_data),
    .restore_valid(restore_valid), .restore_index(restore_index),
    .restore_data(restore_data));
  cbf_mem_model mem_i (.clk(clk), .sys_rst(sys_rst), .mem_read(mem_read),
    .mem_address(mem_address), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rq);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk(1, 0);
    rq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic glob(input logic [31:0] a);
    return a[31:16] == 16'h0002 || a[31:16] == 16'h0003 ||
           a[31:16] == 16'hFFFF;
  endfunction
  function automatic void put(input logic [31:0] a, input logic [31:0] d,
                              input logic [1:0] src, input logic fst,
                              input logic [2:0] cl, input logic [19:0] rc);
    mem_i.mem[a] = d;
    if (d != TERM) expq.push_back({rc, cl, src, fst, d});
  endfunction
  // ----------------------------------------
  // monitors
  // ----------------------------------------
  always @(posedge clk) begin
    if (restore_valid === 1'b1) begin
      chk(restore_index, rcnt);
      chk(restore_data,
          (cbase + 32'h40 + {rcnt, 2'b00}) ^ 32'hC3C3_0000);
      rcnt = rcnt + 20'h1;
    end
    if (cmd_valid === 1'b1 &&
        !(cmd_first === 1'b1 && cmd_data == TERM)) begin
      e = (expq.size() > 0) ? expq.pop_front() : '1;
      chk({cmd_client, cmd_source, cmd_first, cmd_data}, e[37:0]);
      chk(rcnt, e[57:38]);
    end
    if (mem_ack === 1'b1 && mem_read === 1'b1) begin
      chk(mem_global, glob(mem_address));
      chk(mem_function, 8'h5C);
    end
  end
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
  // ----------------------------------------
  // one context: restore, hooks, then ring
  // ----------------------------------------
  task automatic run_ctx(input logic [31:0] base, input logic [15:0] lines,
                         input logic [31:0] tail, input logic hk);
    int n;
    bus(1, `CBF_REG_CTX_BASE, base, q);
    bus(1, `CBF_REG_CTX_LINES, {16'h0, lines}, q);
    cbase = base;
    rcnt = 20'h0;
    bus(1, `CBF_REG_CTRL, 32'h0000_0001, q);
    bus(1, `CBF_REG_RING_TAIL, tail, q);
    n = 0;
    do begin
      bus(0, `CBF_REG_STATUS, 0, q);
      bus(0, `CBF_REG_RING_HEAD, 0, r);
      n++;
    end while (!(q[2:0] == 3'h5 && r == tail && expq.size() == 0) && n < 500);
    chk(expq.size(), 0);
    chk(rcnt, {lines, 4'h0});
    chk(q[5], hk);
  endtask
  initial begin
    void'($urandom(49));
    rcnt = 20'h0;
    cbase = 32'h0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(0, `CBF_REG_STATUS, 0, q);
    chk(q, 32'h0);
    bus(0, `CBF_REG_FUNC_ID, 0, q);
    chk(q, {24'h0, `CBF_RST_FUNC_ID});
    // lane 0 masked: function id must stay untouched
    avs_byteenable <= 4'h2;
    bus(1, `CBF_REG_FUNC_ID, 32'h0000_A5A5, q);
    avs_byteenable <= 4'hF;
    bus(0, `CBF_REG_FUNC_ID, 0, q);
    chk(q, {24'h0, `CBF_RST_FUNC_ID});
    bus(0, 8'h40, 0, q);
    chk(q, 32'h0);
    bus(1, `CBF_REG_RING_SIZE, 32'hFFFF_FFFF, q);
    bus(0, `CBF_REG_RING_SIZE, 0, q);
    chk(q, {10'h0, `CBF_RING_MAX});
    bus(1, `CBF_REG_RING_SIZE, 32'h0000_1000, q);
    bus(1, `CBF_REG_FUNC_ID, 32'h0000_005C, q);
    bus(1, `CBF_REG_RING_BASE, 32'h0004_0000, q);
    // context with hook at line 1 and a post batch
    mem_i.mem[32'h0001_0000] = 32'h0002_0001;
    mem_i.mem[32'h0001_0004] = 32'h0000_0001;
    mem_i.mem[32'h0001_0008] = 32'h0000_0001;
    mem_i.mem[32'h0001_000C] = 32'h0003_0001;
    put(32'h0002_0000, 32'h2000_0001, 2, 1, 1, 16);
    put(32'h0002_0004, $urandom, 2, 0, 1, 16);
    put(32'h0002_0008, $urandom, 2, 0, 1, 16);
    put(32'h0002_000C, 32'h6000_0000, 2, 1, 3, 16);
    put(32'h0002_0010, $urandom, 2, 0, 3, 16);
    for (int i = 5; i < 16; i++) put(32'h0002_0000 + 4 * i, NOP, 2, 1, 0, 16);
    put(32'h0003_0000, 32'h4000_0000, 1, 1, 2, 32);
    put(32'h0003_0004, $urandom, 1, 0, 2, 32);
    put(32'h0003_0008, NOP, 1, 1, 0, 32);
    put(32'h0003_000C, TERM, 1, 1, 0, 32);
    put(32'h0004_0000, LAUNCH, 0, 1, 0, 32);
    put(32'h0004_0004, 32'hFFFF_F000, 0, 0, 0, 32);
    put(32'hFFFF_F000, NOP, 1, 1, 0, 32);
    put(32'hFFFF_F004, TERM, 1, 1, 0, 32);
    put(32'h0004_0008, NOP, 0, 1, 0, 32);
    put(32'h0004_000C, NOP, 0, 1, 0, 32);
    run_ctx(32'h0001_0000, 16'h2, 32'h10, 1'b1);
    // 16 hook, 4 post batch, 6 ring and launched batch
    bus(0, `CBF_REG_CMD_COUNT, 0, q);
    chk(q, 32'h0000_001A);
    // ring stays idle at head 0x10; next context continues there
    // context with both hooks disabled
    mem_i.mem[32'h0005_0000] = 32'h0002_0000;
    mem_i.mem[32'h0005_0004] = 32'h0000_0001;
    mem_i.mem[32'h0005_0008] = 32'h0000_0000;
    mem_i.mem[32'h0005_000C] = 32'h0003_0000;
    put(32'h0004_0010, 32'hE000_0000 | ($urandom & 32'hFFFF), 0, 1, 7, 16);
    put(32'h0004_0014, NOP, 0, 1, 0, 16);
    run_ctx(32'h0005_0000, 16'h1, 32'h18, 1'b0);
    close_out();
  end
endmodule
